// ===== msa_pkg.sv
// Purpose: Shared constants and types for the multistop sweep acquisition block
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register access
// Notes: Times are held in 100 ps bins; software counts are in 6.4 ns units
package msa_pkg;
    // Timing
    localparam int CLK_PERIOD_PS = 10000;
    localparam int BIN_PS = 100;
    localparam int TICK_BINS_I = CLK_PERIOD_PS / BIN_PS;
    localparam int UNIT_SHIFT = 6;
    localparam int DLY_STEP_PS = 3200;
    localparam int DEAD_TIME_NS = 96;
    localparam int DEAD_CYCLES = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Widths
    localparam int TIME_W = 54;
    localparam int CNT_W = 48;
    localparam int TAG_W = 16;
    localparam int GPIO_W = 8;
    localparam int DAC_W = 14;
    localparam int DLY_W = 4;
    localparam int DLY_CYC_W = 3;
    localparam int NCHAN = 3;
    localparam int CHAN_W = 2;
    localparam int SEL_W = 6;
    localparam int NCNT = 4;
    localparam int EVT_W = TAG_W + CHAN_W + 1 + TIME_W;
    localparam logic [TIME_W-1:0] TICK_BINS = TIME_W'(TICK_BINS_I);
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CNT_BASE = 8'h08;
    localparam logic [7:0] OFF_SWEEPS_LO = 8'h28;
    localparam logic [7:0] OFF_SWEEPS_HI = 8'h2c;
    localparam logic [7:0] OFF_SYNC = 8'h30;
    localparam logic [7:0] OFF_GPIO = 8'h34;
    localparam logic [7:0] OFF_DAC = 8'h38;
    // Index of the 48-bit count registers, lo word at base + 8*k
    localparam int CNT_ACQ_DELAY = 0;
    localparam int CNT_RANGE = 1;
    localparam int CNT_HOLDOFF = 2;
    localparam int CNT_PRESET = 3;
    // Control fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_GO_OUT_EN = 1;
    localparam int CTRL_GO_WATCH_EN = 2;
    localparam int CTRL_GO_PULL = 3;
    localparam int CTRL_PRESET_EN = 4;
    localparam int CTRL_TAG_EN = 5;
    localparam int CTRL_REF_EXT = 6;
    localparam int CTRL_IN_DLY_LSB = 8;
    localparam int CTRL_CHEN_LSB = 12;
    localparam int CTRL_EDGE_LSB = 16;
    localparam logic [31:0] CTRL_MASK = 32'h003f_7f7f;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Sync fields
    localparam int SYNC1_SEL_LSB = 0;
    localparam int SYNC1_INV = 6;
    localparam int SYNC2_SEL_LSB = 8;
    localparam int SYNC2_INV = 14;
    localparam logic [31:0] SYNC_RST = 32'h0000_0000;
    // GPIO fields
    localparam int GPIO_DIR_LSB = 0;
    localparam int GPIO_OUT_LSB = 8;
    localparam int GPIO_PIN_LSB = 16;
    // Sync source codes
    localparam logic [SEL_W-1:0] SRC_ZERO = 6'h00;
    localparam logic [SEL_W-1:0] SRC_GO = 6'h01;
    localparam logic [SEL_W-1:0] SRC_BEGIN = 6'h02;
    localparam logic [SEL_W-1:0] SRC_ARMED = 6'h03;
    localparam logic [SEL_W-1:0] SRC_SYS_ON = 6'h04;
    localparam logic [SEL_W-1:0] SRC_WINDOW = 6'h05;
    localparam logic [SEL_W-1:0] SRC_HOLD = 6'h06;
    localparam logic [SEL_W-1:0] SRC_DEAD = 6'h07;
    localparam logic [SEL_W-1:0] SRC_CHAN0 = 6'h08;
    localparam logic [SEL_W-1:0] SRC_FAST0 = 6'h0c;
    localparam logic [SEL_W-1:0] SRC_TIME0 = 6'h10;
    localparam logic [SEL_W-1:0] SRC_SWEEP0 = 6'h30;
    localparam int NFAST = 4;
    localparam int NTIME = 32;
    localparam int TIME_TAP_LSB = 6;
    localparam int NSWEEP_SRC = 12;

    typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_SWEEP, ST_DEAD, ST_HOLD} msa_state_t;

    // Sources toggling above 100 MHz
    function automatic logic msa_is_fast(input logic [SEL_W-1:0] sel);
        return (sel >= SRC_FAST0) && (sel < SRC_TIME0);
    endfunction
endpackage

// ===== msa_chan_if.sv
// Purpose: Carries raw and delayed input channel levels to the delay line
// Assumes: Levels synchronous to the system clock
// Notes: Bit 0 is the start input, higher bits the stop inputs
`timescale 1ns/1ps
interface msa_chan_if
    import msa_pkg::*;
();
    logic [NCHAN-1:0] raw;
    logic [NCHAN-1:0] delayed;
    logic [DLY_CYC_W-1:0] dly_cyc;
    modport src (output raw, output dly_cyc, input delayed);
    modport line (input raw, input dly_cyc, output delayed);
endinterface

// ===== msa_delay_line.sv
// Purpose: Whole-cycle adjustable delay of the start and stop levels
// Assumes: dly_cyc never exceeds DEPTH
// Notes: Sub-cycle steps round down to whole clock cycles
`timescale 1ns/1ps
module msa_delay_line
    import msa_pkg::*;
#(
    parameter int DEPTH = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Channels
    msa_chan_if.line chan
);
    logic [NCHAN-1:0] pipe [DEPTH];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                pipe[i] <= '0;
            end
        end else begin
            pipe[0] <= chan.raw;
            for (int i = 1; i < DEPTH; i++) begin
                pipe[i] <= pipe[i-1];
            end
        end
    end

    always_comb begin
        chan.delayed = chan.raw;
        if (chan.dly_cyc != '0) begin
            chan.delayed = pipe[chan.dly_cyc - 1'b1];
        end
    end
endmodule

// ===== msa_sweep_ctrl.sv
// Purpose: Sweep sequencing, event capture and sync/run-line control
// Assumes: Channel, tag and run-line inputs synchronous to clk_i
// Notes: One event per cycle leaves the block; lowest channel wins a tie
// What this block does
// R1 - Each sync output has its own software-selected polarity inversion.
// R2 - Secondary sync output refuses sources faster than 100 MHz.
// R3 - Sweep counter increments when a sweep starts, not when it ends.
// R4 - Primary sync output drives true as low level unless inverted.
// R5 - When enabled, 16 tag bits are sampled and stored with each event.
// R6 - Software delay on start and stop inputs, 15 steps of 3.2 ns; the code rounds down to whole 10 ns cycles.
// R7 - Software enables, disables, sets and resets the shared run line.
// R8 - With run-line watch enabled, a low line halts the measurement.
// R9 - Arming releases the open-drain run line, halting pulls it low.
// R10 - Each general I/O bit is input only or open-drain with readback.
// R11 - A 14-bit software code sets the auxiliary analogue level.
// R12 - Software selects internal or external 10 MHz reference.
// R13 - Event times count in 100 ps bins over 54 bits from sweep start.
// R14 - Timer bits 6 to 37 are selectable as sync timer taps.
// R15 - Start input can act as event channel; events carry channel number.
// R16 - Once armed, a start edge begins the sweep; stops are timestamped.
// R17 - Stop edges rising, falling or both; event records its edge.
// R18 - Acquisition delay in 6.4 ns units suppresses early stop events.
// R19 - Range expiry ends the sweep; 96 ns dead time then re-arm; the code rounds it up to 10 cycles, 100 ns.
// R20 - Hold-off time after sweep end blocks new starts.
// R21 - Delay, range and hold-off are 48-bit counts of 6.4 ns.
// R22 - Events outside the acquisition window are discarded.
// R23 - 48-bit sweep counter with preset; reaching it blocks new sweeps.
// R24 - Sweep begin pulse is selectable onto the sync outputs.
// R25 - Reset idles the sequencer, clears sweep count, releases run line.
// R26 - Edges during dead time or hold-off are dropped, start nothing.
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module msa_sweep_ctrl
    import msa_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Discriminated inputs
    input wire logic start_i,
    input wire logic [NCHAN-2:0] stop_i,
    input wire logic [TAG_W-1:0] tag_i,
    input wire logic [NFAST-1:0] fast_tap_i,
    // Event stream
    output logic evt_valid_o,
    output logic [EVT_W-1:0] evt_word_o,
    // Run line
    input wire logic go_i,
    output logic go_o,
    output logic go_oe_o,
    // General I/O
    input wire logic [GPIO_W-1:0] gpio_i,
    output logic [GPIO_W-1:0] gpio_o,
    output logic [GPIO_W-1:0] gpio_oe_o,
    // Sync, analogue and reference
    output logic sync1_o,
    output logic sync2_o,
    output logic [DAC_W-1:0] dac_code_o,
    output logic ref_ext_sel_o
);
    msa_chan_if chan ();

    logic [31:0] ctrl;
    logic [31:0] sync_cfg;
    logic [GPIO_W-1:0] gpio_dir;
    logic [GPIO_W-1:0] gpio_out;
    logic [CNT_W-1:0] cnt_reg [NCNT];
    logic [CNT_W-1:0] sweeps;
    msa_state_t state;
    logic [TIME_W-1:0] time_cnt;
    logic [3:0] dead_cnt;
    logic [NCHAN-1:0] prev_lvl;
    logic [TAG_W-1:0] tag_q;
    logic begin_pulse;
    logic [31:0] rdata;
    logic [31:0] wdata;
    logic wr_go;
    logic halt;
    logic preset_hit;
    logic [NCHAN-1:0] hit;
    logic [NCHAN-1:0] rise;
    logic [TIME_W:0] dly_bins;
    logic [TIME_W:0] end_bins;
    logic [TIME_W:0] hold_bins;
    logic [TIME_W:0] time_next_ext;
    logic in_window;
    logic [63:0] src_vec;
    logic [31:0] dly_prod;

    function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [TIME_W:0] to_bins(input logic [CNT_W:0] units);
        return {units, {UNIT_SHIFT{1'b0}}};
    endfunction

    // Input delay, rounded down to whole cycles
    assign dly_prod = 32'(ctrl[CTRL_IN_DLY_LSB +: DLY_W]) * 32'(DLY_STEP_PS) / 32'(CLK_PERIOD_PS);
    assign chan.raw = {stop_i, start_i};
    assign chan.dly_cyc = dly_prod[DLY_CYC_W-1:0]; // R6

    msa_delay_line #(
        .DEPTH(5)
    ) u_delay (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .chan(chan)
    );

    // Bus decode
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wdata = merge(rdata, wb_dat_i, wb_sel_i);

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            OFF_CTRL: rdata = ctrl;
            OFF_STATUS: rdata = {27'h0, preset_hit, go_i, 3'(state)};
            OFF_SWEEPS_LO: rdata = sweeps[31:0];
            OFF_SWEEPS_HI: rdata = {16'h0, sweeps[CNT_W-1:32]};
            OFF_SYNC: rdata = sync_cfg;
            OFF_GPIO: rdata = {8'h00, gpio_i, gpio_out, gpio_dir};
            OFF_DAC: rdata = {18'h0, dac_code_o};
            default: begin
                for (int k = 0; k < NCNT; k++) begin
                    if (wb_adr_i == OFF_CNT_BASE + 8'(8 * k)) begin
                        rdata = cnt_reg[k][31:0];
                    end
                    if (wb_adr_i == OFF_CNT_BASE + 8'(8 * k + 4)) begin
                        rdata = {16'h0, cnt_reg[k][CNT_W-1:32]};
                    end
                end
            end
        endcase
    end

    // Single wait state, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_dat_o <= rdata;
            end
        end
    end

    // Control; a software write beats a same-cycle halt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RST;
        end else if (wr_go && wb_adr_i == OFF_CTRL) begin
            ctrl <= wdata & CTRL_MASK; // R7
        end else if (halt) begin
            ctrl[CTRL_RUN] <= 1'b0; // R8
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < NCNT; k++) begin
                cnt_reg[k] <= '0;
            end
        end else if (wr_go) begin
            for (int k = 0; k < NCNT; k++) begin
                if (wb_adr_i == OFF_CNT_BASE + 8'(8 * k)) begin
                    cnt_reg[k][31:0] <= wdata; // R21
                end
                if (wb_adr_i == OFF_CNT_BASE + 8'(8 * k + 4)) begin
                    cnt_reg[k][CNT_W-1:32] <= wdata[15:0]; // R21
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_cfg <= SYNC_RST;
            gpio_dir <= '0;
            gpio_out <= '0;
            dac_code_o <= '0;
        end else if (wr_go) begin
            if (wb_adr_i == OFF_SYNC) begin
                sync_cfg <= {17'h0, wdata[14:8], 1'b0, wdata[6:0]}; // R1
            end
            if (wb_adr_i == OFF_GPIO) begin
                gpio_dir <= wdata[GPIO_DIR_LSB +: GPIO_W];
                gpio_out <= wdata[GPIO_OUT_LSB +: GPIO_W];
            end
            if (wb_adr_i == OFF_DAC) begin
                dac_code_o <= wdata[DAC_W-1:0]; // R11
            end
        end
    end

    // Sweep timing in bins
    assign halt = ctrl[CTRL_GO_WATCH_EN] && !go_i; // R8
    assign preset_hit = ctrl[CTRL_PRESET_EN] && (sweeps >= cnt_reg[CNT_PRESET]); // R23
    assign dly_bins = to_bins({1'b0, cnt_reg[CNT_ACQ_DELAY]}); // R18
    assign end_bins = to_bins({1'b0, cnt_reg[CNT_ACQ_DELAY]} + {1'b0, cnt_reg[CNT_RANGE]});
    assign hold_bins = to_bins({1'b0, cnt_reg[CNT_HOLDOFF]}); // R20
    assign time_next_ext = {1'b0, time_cnt} + {1'b0, TICK_BINS};
    assign in_window = (state == ST_SWEEP) && ({1'b0, time_cnt} >= dly_bins); // R22

    always_comb begin
        for (int c = 0; c < NCHAN; c++) begin
            rise[c] = chan.delayed[c] && !prev_lvl[c];
            hit[c] = (rise[c] && ctrl[CTRL_EDGE_LSB + 2 * c])
                || (!chan.delayed[c] && prev_lvl[c] && ctrl[CTRL_EDGE_LSB + 2 * c + 1]); // R17
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_lvl <= '0;
        end else begin
            prev_lvl <= chan.delayed;
        end
    end

    // Sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE; // R25
            time_cnt <= '0;
            dead_cnt <= '0;
        end else if (!ctrl[CTRL_RUN] || halt) begin
            state <= ST_IDLE; // R8
            time_cnt <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    state <= ST_ARMED;
                end
                ST_ARMED: begin
                    time_cnt <= '0;
                    if (hit[0] && !preset_hit) begin
                        state <= ST_SWEEP; // R16
                    end
                end
                ST_SWEEP: begin
                    time_cnt <= time_next_ext[TIME_W-1:0]; // R13
                    if (time_next_ext >= end_bins) begin
                        state <= ST_DEAD; // R19
                        dead_cnt <= 4'(DEAD_CYCLES - 1);
                    end
                end
                ST_DEAD: begin
                    time_cnt <= '0;
                    if (dead_cnt == '0) begin
                        state <= (hold_bins == '0) ? ST_ARMED : ST_HOLD; // R19
                    end else begin
                        dead_cnt <= dead_cnt - 1'b1;
                    end
                end
                ST_HOLD: begin
                    time_cnt <= time_next_ext[TIME_W-1:0];
                    if (time_next_ext >= hold_bins) begin
                        state <= ST_ARMED; // R20
                        time_cnt <= '0;
                    end
                end
            endcase
        end
    end

    // Sweep count and begin pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sweeps <= '0; // R25
            begin_pulse <= 1'b0;
        end else begin
            begin_pulse <= 1'b0;
            if (ctrl[CTRL_RUN] && !halt && state == ST_ARMED && hit[0] && !preset_hit) begin
                sweeps <= sweeps + 1'b1; // R3
                begin_pulse <= 1'b1; // R24
            end
        end
    end

    // Event capture; edges outside the sweep never reach the stream
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tag_q <= '0;
            evt_valid_o <= 1'b0;
            evt_word_o <= '0;
        end else begin
            tag_q <= ctrl[CTRL_TAG_EN] ? tag_i : '0; // R5
            evt_valid_o <= 1'b0;
            for (int c = NCHAN - 1; c >= 0; c--) begin
                if (hit[c] && ctrl[CTRL_CHEN_LSB + c] && in_window && !halt) begin // R26
                    evt_valid_o <= 1'b1; // R22
                    evt_word_o <= {tag_q, CHAN_W'(c), rise[c], time_cnt}; // R15
                end
            end
        end
    end

    // Run line and general I/O, both open drain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_o <= 1'b0;
            go_oe_o <= 1'b0; // R25
            gpio_o <= '0;
            gpio_oe_o <= '0;
            ref_ext_sel_o <= 1'b0;
        end else begin
            go_o <= 1'b0;
            // No pull while arming, our own watch would halt us
            go_oe_o <= ctrl[CTRL_GO_OUT_EN] && (!ctrl[CTRL_RUN] || ctrl[CTRL_GO_PULL]); // R9
            gpio_o <= '0;
            gpio_oe_o <= gpio_dir & ~gpio_out; // R10
            ref_ext_sel_o <= ctrl[CTRL_REF_EXT]; // R12
        end
    end

    // Sync sources
    always_comb begin
        src_vec = 64'h0;
        src_vec[SRC_GO] = go_i;
        src_vec[SRC_BEGIN] = begin_pulse; // R24
        src_vec[SRC_ARMED] = (state == ST_ARMED);
        src_vec[SRC_SYS_ON] = ctrl[CTRL_RUN] && (state != ST_IDLE);
        src_vec[SRC_WINDOW] = in_window;
        src_vec[SRC_HOLD] = (state == ST_HOLD);
        src_vec[SRC_DEAD] = (state == ST_DEAD);
        src_vec[SRC_CHAN0 +: NCHAN] = chan.delayed;
        src_vec[SRC_FAST0 +: NFAST] = fast_tap_i;
        if (state == ST_SWEEP) begin
            src_vec[SRC_TIME0 +: NTIME] = time_cnt[TIME_TAP_LSB +: NTIME]; // R14
        end
        src_vec[SRC_SWEEP0 +: NSWEEP_SRC] = sweeps[NSWEEP_SRC-1:0];
        src_vec[SRC_ZERO] = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_o <= 1'b1;
            sync2_o <= 1'b0;
        end else begin
            sync1_o <= ~(src_vec[sync_cfg[SYNC1_SEL_LSB +: SEL_W]] ^ sync_cfg[SYNC1_INV]); // R4
            sync2_o <= (!msa_is_fast(sync_cfg[SYNC2_SEL_LSB +: SEL_W])
                && src_vec[sync_cfg[SYNC2_SEL_LSB +: SEL_W]]) ^ sync_cfg[SYNC2_INV]; // R2
        end
    end
endmodule

// ===== msa_far_side.sv
// Purpose: Far side of the sweep block: detector levels, run line, I/O pins
// Assumes: Run line and I/O pins carry pull-ups
// Notes: Other instruments pull low only when the bench says so
`timescale 1ns/1ps
module msa_far_side (
    // Clock
    input wire logic clk_i,
    // Device pull-downs
    input wire logic go_oe_i,
    input wire logic [7:0] gpio_oe_i,
    // Lines seen by the device
    output logic [2:0] chan_o,
    output logic go_o,
    output logic [7:0] gpio_o
);
    logic ext_go_low;
    logic [7:0] ext_pin_low;
    initial begin
        chan_o = 3'h0;
        ext_go_low = 1'b0;
        ext_pin_low = 8'h00;
    end
    // Pull-up wins until any party pulls low
    assign go_o = !(go_oe_i === 1'b1 || ext_go_low);
    assign gpio_o = (^gpio_oe_i === 1'bx) ? ~ext_pin_low : ~(gpio_oe_i | ext_pin_low);
    task automatic set_chan(input int ch, input logic lvl, input int gap);
        repeat (gap) @(posedge clk_i);
        chan_o[ch] <= lvl;
    endtask
endmodule

// ===== msa_sweep_ctrl_properties.sv
// Purpose: Port-level checks of the sweep block
// Assumes: Single clock, synchronous active-high reset
// Notes: Register contents are not visible here
`timescale 1ns/1ps
module msa_sweep_ctrl_properties
    import msa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic evt_valid_o,
    input wire logic [EVT_W-1:0] evt_word_o,
    input wire logic go_o,
    input wire logic go_oe_o,
    input wire logic [GPIO_W-1:0] gpio_o,
    input wire logic sync1_o,
    input wire logic sync2_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_single: assert property (s_req |=> s_ack_pulse)
        else $error("ack not a single pulse after request");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_rdata_held: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved without ack");
    a_reset_quiet: assert property ($fell(rst_i) |-> !go_oe_o && !evt_valid_o && sync1_o && !sync2_o)
        else $error("outputs not idle after reset");
    a_evt_bins: assert property (evt_valid_o |-> evt_word_o[TIME_W-1:0] % TICK_BINS == 0)
        else $error("event time off the bin grid");
    a_evt_chan: assert property (evt_valid_o |-> evt_word_o[TIME_W+1 +: CHAN_W] < NCHAN)
        else $error("event channel out of range");
    a_evt_held: assert property (!evt_valid_o |-> $stable(evt_word_o))
        else $error("event word moved without valid");
    a_open_drain: assert property (go_o == 1'b0 && gpio_o == '0)
        else $error("open-drain pin driven high");
    c_event: cover property (evt_valid_o);
endmodule
bind msa_sweep_ctrl msa_sweep_ctrl_properties msa_sweep_ctrl_properties_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .evt_valid_o,
    .evt_word_o, .go_o, .go_oe_o, .gpio_o, .sync1_o, .sync2_o
);

// ===== msa_sweep_ctrl_tb.sv
// Purpose: Self-checking bench of the sweep block
// Assumes: Stimulus on rising edges, fixed seed
// Notes: Short counts keep each sweep a few dozen cycles
`timescale 1ns/1ps
module msa_sweep_ctrl_tb;
    import msa_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [TAG_W-1:0] tag_i = 16'h0;
    logic [NFAST-1:0] fast_tap_i = 4'h0;
    logic [31:0] wb_dat_o, rd, v;
    logic wb_ack_o, evt_valid_o, go_i, go_o, go_oe_o, sync1_o, sync2_o, ref_ext_sel_o, saw_hold;
    logic [2:0] chan;
    logic [EVT_W-1:0] evt_word_o;
    logic [GPIO_W-1:0] gpio_i, gpio_o, gpio_oe_o, e;
    logic [DAC_W-1:0] dac_code_o;
    logic [EVT_W-1:0] evq[$];
    int mismatches = 0;
    int check_count = 0;
    int seed = 88817;
    int cycles = 0;
    int n;
    always #5 clk_i = ~clk_i;
    msa_sweep_ctrl msa_sweep_ctrl_inst (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .start_i(chan[0]), .stop_i(chan[2:1]), .tag_i, .fast_tap_i,
        .evt_valid_o, .evt_word_o, .go_i, .go_o, .go_oe_o, .gpio_i, .gpio_o, .gpio_oe_o,
        .sync1_o, .sync2_o, .dac_code_o, .ref_ext_sel_o
    );
    msa_far_side msa_far_side_inst (
        .clk_i, .go_oe_i(go_oe_o), .gpio_oe_i(gpio_oe_o), .chan_o(chan), .go_o(go_i),
        .gpio_o(gpio_i)
    );
    // Fast taps take a new random value every cycle so a leak onto the slow output shows
    always @(posedge clk_i) begin
        fast_tap_i <= 4'($random(seed));
        cycles <= cycles + 1;
        if (evt_valid_o === 1'b1) evq.push_back(evt_word_o);
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end
    task automatic close_out();
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_evt(input logic [EVT_W-1:0] got, input logic [EVT_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [EVT_W-1:0] evt_exp(input logic [1:0] ch, input logic r, input int t);
        return {tag_i, ch, r, TIME_W'(t)};
    endfunction
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        tag_i <= 16'($random(seed));
        wb(0, OFF_STATUS, 0);
        chk(rd, 32'h8);
        wb(0, OFF_SWEEPS_LO, 0);
        chk(rd, 32'h0);
        wb(1, 8'hfc, $random(seed));
        wb(0, 8'hfc, 0);
        chk(rd, 32'h0);
        v = $random(seed) & 32'hffff_fffe;
        wb(1, OFF_CTRL, v);
        wb(0, OFF_CTRL, 0);
        chk(rd, v & CTRL_MASK);
        chk(ref_ext_sel_o, v[CTRL_REF_EXT]);
        chk(go_oe_o, v[CTRL_GO_OUT_EN]);
        for (int k = 0; k < NCNT; k++) begin
            v = $random(seed);
            wb(1, OFF_CNT_BASE + 8'(8 * k), v);
            wb(1, OFF_CNT_BASE + 8'(8 * k + 4), ~v);
            wb(0, OFF_CNT_BASE + 8'(8 * k), 0);
            chk(rd, v);
            wb(0, OFF_CNT_BASE + 8'(8 * k + 4), 0);
            chk(rd, ~v & 32'hffff);
        end
        repeat (4) begin
            v = $random(seed);
            e = 8'($random(seed));
            msa_far_side_inst.ext_pin_low <= e;
            wb(1, OFF_GPIO, v);
            wb(1, OFF_DAC, v);
            wb(0, OFF_GPIO, 0);
            chk(gpio_oe_o, v[7:0] & ~v[15:8]);
            chk(rd, {8'h0, ~(e | (v[7:0] & ~v[15:8])), v[15:0]});
            chk(dac_code_o, v[13:0]);
        end
        for (int i = 0; i < 2; i++) begin
            wb(1, OFF_SYNC, {17'h0, i[0], SRC_FAST0, 1'b0, i[0], SRC_ZERO});
            repeat (2) @(posedge clk_i);
            chk(sync1_o, !i[0]);
            chk(sync2_o, i[0]);
        end
        // Delay 1, range 20, hold-off 20 in 6.4 ns units, preset 2 sweeps
        for (int k = 0; k < NCNT; k++) begin
            wb(1, OFF_CNT_BASE + 8'(8 * k), (k == 3) ? 2 : (k == 0) ? 1 : 20);
            wb(1, OFF_CNT_BASE + 8'(8 * k + 4), 0);
        end
        wb(1, OFF_SYNC, {18'h0, SRC_SWEEP0, 2'h0, SRC_ARMED});
        wb(1, OFF_CTRL, 32'h000d_2033);
        wb(0, OFF_STATUS, 0);
        chk(rd, 32'h9);
        chk(go_oe_o, 1'b0);
        chk(sync1_o, 1'b0);
        for (int s = 0; s < 3; s++) begin
            msa_far_side_inst.set_chan(0, 1'b1, 1);
            msa_far_side_inst.set_chan(1, 1'b1, 1);
            msa_far_side_inst.set_chan(1, 1'b0, 1);
            msa_far_side_inst.set_chan(1, 1'b1, 2);
            wb(0, OFF_SWEEPS_LO, 0);
            chk(rd, (s == 0) ? 1 : 2);
            msa_far_side_inst.set_chan(1, 1'b0, 10);
            msa_far_side_inst.set_chan(0, 1'b0, 1);
            saw_hold = 1'b0;
            n = 0;
            do begin
                wb(0, OFF_STATUS, 0);
                if (rd[2:0] == 3'h4) saw_hold = 1'b1;
                n++;
            end while (rd[2:0] != 3'h1 && n < 300);
            chk(saw_hold, s < 2);
            chk(rd[4:0], (s > 0) ? 5'h19 : 5'h09);
            chk(sync2_o, s == 0);
            if (s < 2) begin
                chk_evt(evq.pop_front(), evt_exp(2'd1, 1'b0, 100));
                chk_evt(evq.pop_front(), evt_exp(2'd1, 1'b1, 300));
            end
            chk(evq.size(), 0);
        end
        wb(1, OFF_CTRL, 32'h000d_2037);
        msa_far_side_inst.ext_go_low <= 1'b1;
        repeat (3) @(posedge clk_i);
        wb(0, OFF_STATUS, 0);
        chk(rd, 32'h10);
        wb(0, OFF_CTRL, 0);
        chk(rd, 32'h000d_2036);
        chk(go_oe_o, 1'b1);
        msa_far_side_inst.ext_go_low <= 1'b0;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, OFF_SWEEPS_LO, 0);
        chk(rd, 32'h0);
        wb(1, OFF_CTRL, 32'h0000_000b);
        wb(0, OFF_STATUS, 0);
        chk(rd, 32'h1);
        chk(go_oe_o, 1'b1);
        close_out();
    end
endmodule
